// >>> ivp_pkg.sv
// Constants, types and the source table of the interrupt vector and priority map.
`default_nettype none
package ivp_pkg;

	// Register bus shape.
	localparam int IVP_ADDR_W = 8;
	localparam int IVP_DATA_W = 16;
	localparam int IVP_NUM_REGS = 8;

	// Register byte offsets.
	localparam logic [7:0] IVP_OFS_PIN = 8'h00;
	localparam logic [7:0] IVP_OFS_TMRA = 8'h04;
	localparam logic [7:0] IVP_OFS_TMRB = 8'h08;
	localparam logic [7:0] IVP_OFS_TMRC = 8'h0C;
	localparam logic [7:0] IVP_OFS_ADCMT = 8'h10;
	localparam logic [7:0] IVP_OFS_WDT = 8'h14;
	localparam logic [7:0] IVP_OFS_SER = 8'h18;
	localparam logic [7:0] IVP_OFS_LATE = 8'h1C;

	// Register indices (byte offset divided by four).
	localparam logic [2:0] IVP_RI_PIN = 3'h0;
	localparam logic [2:0] IVP_RI_TMRA = 3'h1;
	localparam logic [2:0] IVP_RI_TMRB = 3'h2;
	localparam logic [2:0] IVP_RI_TMRC = 3'h3;
	localparam logic [2:0] IVP_RI_ADCMT = 3'h4;
	localparam logic [2:0] IVP_RI_WDT = 3'h5;
	localparam logic [2:0] IVP_RI_SER = 3'h6;
	localparam logic [2:0] IVP_RI_LATE = 3'h7;

	// Priority field positions: nibble n covers bits 4n+3 down to 4n.
	localparam int IVP_FLD_W = 4;
	localparam logic [1:0] IVP_NIB_15_12 = 2'h3;
	localparam logic [1:0] IVP_NIB_11_8 = 2'h2;
	localparam logic [1:0] IVP_NIB_7_4 = 2'h1;
	localparam logic [1:0] IVP_NIB_3_0 = 2'h0;
	localparam logic [15:0] IVP_PRIO_RST = 16'h0000;

	// Levels carry one extra bit so the non-maskable level sits above 15.
	localparam int IVP_LVL_W = 5;
	localparam logic [4:0] IVP_LVL_NMI = 5'h10;
	localparam logic [4:0] IVP_LVL_DBG = 5'h0F;

	localparam int IVP_NUM_SRC = 56;
	localparam int IVP_IDX_W = 6;
	localparam int IVP_SRC_NMI = 0;
	localparam int IVP_SRC_BRK = 1;
	localparam int IVP_SRC_DBG = 2;
	localparam int IVP_SRC_IRQ0 = 3;
	localparam int IVP_SRC_IRQ1 = 4;
	localparam int IVP_SRC_TMR0_CMPA = 7;
	localparam int IVP_SRC_TMR0_CMPB = 8;
	localparam int IVP_SRC_TMR0_OVF = 11;
	localparam int IVP_SRC_SER3_RXERR = 41;
	localparam int IVP_SRC_SER3_TXEND = 44;

	typedef struct packed {
		logic fixed;
		logic [4:0] flvl;
		logic [2:0] ri;
		logic [1:0] nib;
		logic [7:0] vec;
	} ivp_src_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [IVP_ADDR_W-1:0] addr;
		logic [IVP_DATA_W-1:0] wdata;
	} ivp_bus_t;

	typedef struct packed {
		logic req;
		logic [7:0] vector;
		logic [4:0] level;
		logic [31:0] addr;
	} ivp_irq_t;

	typedef struct packed {
		logic [IVP_NUM_REGS-1:0][IVP_DATA_W-1:0] prio;
		logic [IVP_DATA_W-1:0] rdata;
		ivp_irq_t irq;
	} ivp_state_t;

	function automatic ivp_src_t ivp_fld(input logic [7:0] vec, input logic [2:0] ri,
		input logic [1:0] nib);
		return '{fixed: 1'b0, flvl: 5'h00, ri: ri, nib: nib, vec: vec};
	endfunction

	function automatic ivp_src_t ivp_fix(input logic [7:0] vec, input logic [4:0] lvl);
		return '{fixed: 1'b1, flvl: lvl, ri: 3'h0, nib: 2'h0, vec: vec};
	endfunction

	// Table order is the default order: earlier entries win ties.
	localparam ivp_src_t IVP_SRC_TAB [IVP_NUM_SRC] = '{
		ivp_fix(8'h0B, IVP_LVL_NMI), ivp_fix(8'h0C, IVP_LVL_DBG), ivp_fix(8'h0E, IVP_LVL_DBG),
		ivp_fld(8'h40, IVP_RI_PIN, IVP_NIB_15_12), ivp_fld(8'h41, IVP_RI_PIN, IVP_NIB_11_8),
		ivp_fld(8'h42, IVP_RI_PIN, IVP_NIB_7_4), ivp_fld(8'h43, IVP_RI_PIN, IVP_NIB_3_0),
		ivp_fld(8'h58, IVP_RI_TMRA, IVP_NIB_15_12), ivp_fld(8'h59, IVP_RI_TMRA, IVP_NIB_15_12),
		ivp_fld(8'h5A, IVP_RI_TMRA, IVP_NIB_15_12), ivp_fld(8'h5B, IVP_RI_TMRA, IVP_NIB_15_12),
		ivp_fld(8'h5C, IVP_RI_TMRA, IVP_NIB_11_8),
		ivp_fld(8'h60, IVP_RI_TMRA, IVP_NIB_7_4), ivp_fld(8'h61, IVP_RI_TMRA, IVP_NIB_7_4),
		ivp_fld(8'h64, IVP_RI_TMRA, IVP_NIB_3_0), ivp_fld(8'h65, IVP_RI_TMRA, IVP_NIB_3_0),
		ivp_fld(8'h68, IVP_RI_TMRB, IVP_NIB_15_12), ivp_fld(8'h69, IVP_RI_TMRB, IVP_NIB_15_12),
		ivp_fld(8'h6C, IVP_RI_TMRB, IVP_NIB_11_8), ivp_fld(8'h6D, IVP_RI_TMRB, IVP_NIB_11_8),
		ivp_fld(8'h70, IVP_RI_TMRB, IVP_NIB_7_4), ivp_fld(8'h71, IVP_RI_TMRB, IVP_NIB_7_4),
		ivp_fld(8'h72, IVP_RI_TMRB, IVP_NIB_7_4), ivp_fld(8'h73, IVP_RI_TMRB, IVP_NIB_7_4),
		ivp_fld(8'h74, IVP_RI_TMRB, IVP_NIB_3_0),
		ivp_fld(8'h78, IVP_RI_TMRC, IVP_NIB_15_12), ivp_fld(8'h79, IVP_RI_TMRC, IVP_NIB_15_12),
		ivp_fld(8'h7A, IVP_RI_TMRC, IVP_NIB_15_12), ivp_fld(8'h7B, IVP_RI_TMRC, IVP_NIB_15_12),
		ivp_fld(8'h7C, IVP_RI_TMRC, IVP_NIB_11_8),
		ivp_fld(8'h88, IVP_RI_ADCMT, IVP_NIB_15_12), ivp_fld(8'h89, IVP_RI_ADCMT, IVP_NIB_15_12),
		ivp_fld(8'h8C, IVP_RI_ADCMT, IVP_NIB_11_8), ivp_fld(8'h90, IVP_RI_ADCMT, IVP_NIB_7_4),
		ivp_fld(8'h94, IVP_RI_ADCMT, IVP_NIB_3_0),
		ivp_fld(8'h98, IVP_RI_WDT, IVP_NIB_15_12), ivp_fld(8'h9C, IVP_RI_WDT, IVP_NIB_11_8),
		ivp_fld(8'hA8, IVP_RI_SER, IVP_NIB_15_12), ivp_fld(8'hA9, IVP_RI_SER, IVP_NIB_15_12),
		ivp_fld(8'hAA, IVP_RI_SER, IVP_NIB_15_12), ivp_fld(8'hAB, IVP_RI_SER, IVP_NIB_15_12),
		ivp_fld(8'hAC, IVP_RI_SER, IVP_NIB_11_8), ivp_fld(8'hAD, IVP_RI_SER, IVP_NIB_11_8),
		ivp_fld(8'hAE, IVP_RI_SER, IVP_NIB_11_8), ivp_fld(8'hAF, IVP_RI_SER, IVP_NIB_11_8),
		ivp_fld(8'hB0, IVP_RI_SER, IVP_NIB_7_4), ivp_fld(8'hB1, IVP_RI_SER, IVP_NIB_7_4),
		ivp_fld(8'hB2, IVP_RI_SER, IVP_NIB_7_4), ivp_fld(8'hB3, IVP_RI_SER, IVP_NIB_7_4),
		ivp_fld(8'hB4, IVP_RI_SER, IVP_NIB_3_0), ivp_fld(8'hB5, IVP_RI_SER, IVP_NIB_3_0),
		ivp_fld(8'hC8, IVP_RI_LATE, IVP_NIB_15_12),
		ivp_fld(8'hD0, IVP_RI_LATE, IVP_NIB_7_4), ivp_fld(8'hD1, IVP_RI_LATE, IVP_NIB_7_4),
		ivp_fld(8'hD2, IVP_RI_LATE, IVP_NIB_7_4), ivp_fld(8'hD3, IVP_RI_LATE, IVP_NIB_7_4)
	};

endpackage
`default_nettype wire

// >>> ivp_arbiter.sv
// Highest-level request selector with ties going to the lowest index.
`default_nettype none
module ivp_arbiter #(
	parameter int N = 56,
	parameter int LW = 5,
	parameter int IW = 6
) (
	// Requests and their levels.
	input wire logic [N-1:0] i_req,
	input wire logic [N-1:0][LW-1:0] i_lvl,
	// Winner.
	output logic o_found,
	output logic [IW-1:0] o_idx
);

	logic [LW-1:0] best;

	// A strict comparison keeps the earlier entry on a tie, and a level of
	// zero can never beat the starting value, so it is never selected.
	always_comb begin
		best = '0;
		o_found = 1'b0;
		o_idx = '0;
		for (int i = 0; i < N; i++) begin
			if (i_req[i] && (i_lvl[i] > best)) begin
				best = i_lvl[i];
				o_idx = IW'(i);
				o_found = 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// >>> ivp_map.sv
// Interrupt vector and priority map: priority registers, selection and CPU request.
`default_nettype none
module ivp_map
	import ivp_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Register port.
	input wire ivp_bus_t i_bus,
	output logic [IVP_DATA_W-1:0] o_rdata,
	// Source requests, table order.
	input wire logic [IVP_NUM_SRC-1:0] i_src_req,
	// CPU side.
	input wire logic [3:0] i_cpu_mask_level,
	output ivp_irq_t o_irq
);

	ivp_state_t s_r;
	ivp_state_t s_nxt;

	logic [IVP_NUM_SRC-1:0][IVP_LVL_W-1:0] src_lvl;
	logic win_found;
	logic [IVP_IDX_W-1:0] win_idx;
	logic reg_hit;
	logic [2:0] reg_idx;
	ivp_src_t win_ent;
	logic [IVP_LVL_W-1:0] win_lvl;

	function automatic logic [IVP_FLD_W-1:0] ivp_field(
		input logic [IVP_NUM_REGS-1:0][IVP_DATA_W-1:0] prio,
		input logic [2:0] ri,
		input logic [1:0] nib);
		logic [IVP_DATA_W-1:0] word;
		word = prio[ri];
		return word[nib*IVP_FLD_W +: IVP_FLD_W];
	endfunction

	function automatic logic [31:0] ivp_vec_addr(input logic [7:0] vec);
		return {22'h00_0000, vec, 2'b00};
	endfunction

	function automatic logic ivp_listed(input logic [7:0] vec);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < IVP_NUM_SRC; i++) begin
			if (IVP_SRC_TAB[i].vec == vec) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// The priority registers are word aligned; anything else is unmapped.
	assign reg_hit = (i_bus.addr[1:0] == 2'b00) && (i_bus.addr[7:5] == 3'b000);
	assign reg_idx = i_bus.addr[4:2];

	// Each source looks up its level from its table entry.
	always_comb begin
		for (int i = 0; i < IVP_NUM_SRC; i++) begin
			if (IVP_SRC_TAB[i].fixed) begin
				src_lvl[i] = IVP_SRC_TAB[i].flvl;
			end else begin
				src_lvl[i] = {1'b0, ivp_field(s_r.prio, IVP_SRC_TAB[i].ri,
					IVP_SRC_TAB[i].nib)};
			end
		end
	end

	// Table order gives both the in-field ranking and the default order.
	ivp_arbiter #(
		.N(IVP_NUM_SRC),
		.LW(IVP_LVL_W),
		.IW(IVP_IDX_W)
	) u_arb (
		.i_req(i_src_req),
		.i_lvl(src_lvl),
		.o_found(win_found),
		.o_idx(win_idx)
	);

	assign win_ent = IVP_SRC_TAB[win_idx];
	assign win_lvl = src_lvl[win_idx];

	always_comb begin
		s_nxt = s_r;
		if (i_bus.wr && reg_hit) begin
			s_nxt.prio[reg_idx] = i_bus.wdata;
		end
		if (i_bus.rd && reg_hit) begin
			s_nxt.rdata = s_r.prio[reg_idx];
		end else begin
			s_nxt.rdata = '0;
		end
		// Only table vectors can ever be driven, so reserved numbers never appear.
		if (win_found && (win_lvl > {1'b0, i_cpu_mask_level})) begin
			s_nxt.irq.req = 1'b1;
			s_nxt.irq.vector = win_ent.vec;
			s_nxt.irq.level = win_lvl;
			s_nxt.irq.addr = ivp_vec_addr(win_ent.vec);
		end else begin
			s_nxt.irq = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_r.prio <= {IVP_NUM_REGS{IVP_PRIO_RST}};
			s_r.rdata <= '0;
			s_r.irq <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_rdata = s_r.rdata;
	assign o_irq = s_r.irq;

	// The request is a registered level recomputed every cycle; the CPU applies
	// its own mask update at once, so a lowered request simply drops next cycle.

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	property p_addr;
		o_irq.req |-> (o_irq.addr == {22'h00_0000, o_irq.vector, 2'b00});
	endproperty
	a_addr: assert property (p_addr)
		else $error("vector address is not four times the vector");

	property p_mask;
		o_irq.req |-> (o_irq.level > {1'b0, $past(i_cpu_mask_level)});
	endproperty
	a_mask: assert property (p_mask)
		else $error("request forwarded at or below the mask level");

	property p_zero;
		o_irq.req |-> (o_irq.level != '0);
	endproperty
	a_zero: assert property (p_zero)
		else $error("level zero request forwarded");

	property p_rst;
		$past(i_sys_rst) |-> ((s_r.prio == '0) && !o_irq.req);
	endproperty
	a_rst: assert property (p_rst)
		else $error("priority fields not cleared by reset");

	property p_rdback;
		(i_bus.wr && reg_hit) ##1 (i_bus.rd && !i_bus.wr && ($past(i_bus.addr) == i_bus.addr))
			|=> (o_rdata == $past(i_bus.wdata, 2));
	endproperty
	a_rdback: assert property (p_rdback)
		else $error("priority register does not read back");

	property p_nmi;
		i_src_req[IVP_SRC_NMI] |=> (o_irq.req && (o_irq.vector == 8'h0B));
	endproperty
	a_nmi: assert property (p_nmi)
		else $error("non-maskable request not presented as vector 11");

	property p_irq0;
		($onehot(i_src_req) && i_src_req[IVP_SRC_IRQ0]
			&& (s_r.prio[IVP_RI_PIN][15:12] > i_cpu_mask_level))
			|=> (o_irq.req && (o_irq.vector == 8'h40) && (o_irq.addr == 32'h0000_0100));
	endproperty
	a_irq0: assert property (p_irq0)
		else $error("pin 0 request not presented as vector 64");

	property p_tie;
		(i_src_req[IVP_SRC_IRQ0] && i_src_req[IVP_SRC_IRQ1] && ($countones(i_src_req) == 2)
			&& (s_r.prio[IVP_RI_PIN][15:12] == s_r.prio[IVP_RI_PIN][11:8])
			&& (s_r.prio[IVP_RI_PIN][15:12] > i_cpu_mask_level))
			|=> (o_irq.vector == 8'h40);
	endproperty
	a_tie: assert property (p_tie)
		else $error("equal levels not resolved by default order");

	property p_field;
		(i_src_req[IVP_SRC_TMR0_CMPA] && i_src_req[IVP_SRC_TMR0_CMPB]
			&& ($countones(i_src_req) == 2)
			&& (s_r.prio[IVP_RI_TMRA][15:12] > i_cpu_mask_level))
			|=> (o_irq.req && (o_irq.vector == 8'h58));
	endproperty
	a_field: assert property (p_field)
		else $error("shared field not ranked by lower vector");

	property p_ovf;
		($onehot(i_src_req) && i_src_req[IVP_SRC_TMR0_OVF]
			&& (s_r.prio[IVP_RI_TMRA][11:8] > i_cpu_mask_level))
			|=> (o_irq.req && (o_irq.vector == 8'h5C));
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("timer 0 overflow not presented as vector 92");

	property p_ser3;
		($onehot(i_src_req) && i_src_req[IVP_SRC_SER3_RXERR]
			&& (s_r.prio[IVP_RI_SER][11:8] > i_cpu_mask_level))
			|=> (o_irq.req && (o_irq.vector == 8'hAC));
	endproperty
	a_ser3: assert property (p_ser3)
		else $error("serial 3 receive error not presented as vector 172");

	property p_listed;
		o_irq.req |-> ivp_listed(o_irq.vector);
	endproperty
	a_listed: assert property (p_listed)
		else $error("reserved or unknown vector presented");

	property p_wr;
		(i_bus.wr && reg_hit) |=> (s_r.prio[$past(reg_idx)] == $past(i_bus.wdata));
	endproperty
	a_wr: assert property (p_wr)
		else $error("priority write not stored");

	// Read data must not linger: a stale word would look like a fresh read.
	property p_rd_idle;
		!$past(i_bus.rd) |-> (o_rdata == '0);
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data present without a read");

	property p_rd_unmapped;
		(i_bus.rd && !reg_hit) |=> (o_rdata == '0);
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped read returned data");

	property p_rst_out;
		$past(i_sys_rst) |-> (o_rdata == '0);
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("read data not cleared by reset");

	// An idle request must carry no vector, so the CPU never sees a stale one.
	property p_idle;
		!o_irq.req |-> ((o_irq.vector == '0) && (o_irq.addr == '0) && (o_irq.level == '0));
	endproperty
	a_idle: assert property (p_idle)
		else $error("vector shown without a request");

	property p_drop;
		!(|i_src_req) |=> !o_irq.req;
	endproperty
	a_drop: assert property (p_drop)
		else $error("request forwarded with no source active");

	property p_nmi_lvl;
		(o_irq.req && (o_irq.level == IVP_LVL_NMI)) |-> (o_irq.vector == 8'h0B);
	endproperty
	a_nmi_lvl: assert property (p_nmi_lvl)
		else $error("top level carried by a vector other than 11");

	// Break and debug sit at level 15, so a mask of 15 legally holds them off.
	property p_brk;
		($onehot(i_src_req) && i_src_req[IVP_SRC_BRK] && (i_cpu_mask_level != 4'hF))
			|=> (o_irq.req && (o_irq.vector == 8'h0C));
	endproperty
	a_brk: assert property (p_brk)
		else $error("break request not presented as vector 12");

	property p_dbg;
		($onehot(i_src_req) && i_src_req[IVP_SRC_DBG] && (i_cpu_mask_level != 4'hF))
			|=> (o_irq.req && (o_irq.vector == 8'h0E));
	endproperty
	a_dbg: assert property (p_dbg)
		else $error("debug request not presented as vector 14");

	property p_irq3;
		($onehot(i_src_req) && i_src_req[IVP_SRC_IRQ0 + 3]
			&& (s_r.prio[IVP_RI_PIN][3:0] > i_cpu_mask_level))
			|=> (o_irq.req && (o_irq.vector == 8'h43) && (o_irq.addr == 32'h0000_010C));
	endproperty
	a_irq3: assert property (p_irq3)
		else $error("pin 3 request not presented as vector 67");

	property p_tmr0_last;
		($onehot(i_src_req) && i_src_req[IVP_SRC_TMR0_CMPA + 3]
			&& (s_r.prio[IVP_RI_TMRA][15:12] > i_cpu_mask_level))
			|=> (o_irq.req && (o_irq.vector == 8'h5B));
	endproperty
	a_tmr0_last: assert property (p_tmr0_last)
		else $error("last timer 0 compare not presented as vector 91");

	property p_ser3_end;
		($onehot(i_src_req) && i_src_req[IVP_SRC_SER3_TXEND]
			&& (s_r.prio[IVP_RI_SER][11:8] > i_cpu_mask_level))
			|=> (o_irq.req && (o_irq.vector == 8'hAF));
	endproperty
	a_ser3_end: assert property (p_ser3_end)
		else $error("serial 3 transmit end not presented as vector 175");

	property p_irq0_masked;
		($onehot(i_src_req) && i_src_req[IVP_SRC_IRQ0]
			&& (s_r.prio[IVP_RI_PIN][15:12] <= i_cpu_mask_level))
			|=> !o_irq.req;
	endproperty
	a_irq0_masked: assert property (p_irq0_masked)
		else $error("pin 0 request forwarded at or below the mask");

endmodule
`default_nettype wire

// >>> ivp_cpu_model.sv
// Behavioural CPU core that takes a forwarded request and fetches its vector entry.
`default_nettype none
module ivp_cpu_model
	import ivp_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Request from the map and mask chosen by the running program.
	input wire ivp_irq_t i_irq,
	input wire logic [3:0] i_mask_set,
	// Mask shown to the map and the last fetched entry address.
	output logic [3:0] o_cpu_mask_level,
	output logic [31:0] o_fetch_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	assign o_cpu_mask_level = i_mask_set;
	// The core works out the entry from the vector itself, so a bad address is not hidden.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_fetch_addr <= 32'h0000_0000;
		end else if (i_irq.req) begin
			o_fetch_addr <= 32'(i_irq.vector) << 2;
		end
	end
endmodule
`default_nettype wire

// >>> ivp_map_test.sv
// Self-checking bench for the interrupt vector and priority map.
`default_nettype none
module ivp_map_test
	import ivp_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	ivp_bus_t bus = '0;
	logic [IVP_DATA_W-1:0] rdata;
	logic [IVP_NUM_SRC-1:0] src = '0;
	logic [3:0] mask_set = 4'h0;
	logic [3:0] cpu_mask;
	logic [31:0] fetch;
	ivp_irq_t irq;
	int err_total = 0;
	int checks = 0;
	int pr [IVP_NUM_REGS];
	int vec_used [int];
	logic [31:0] got [IVP_NUM_SRC];
	logic [15:0] rnd = 16'h004C;

	ivp_map u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata),
		.i_src_req(src), .i_cpu_mask_level(cpu_mask), .o_irq(irq));
	ivp_cpu_model u_cpu (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_irq(irq),
		.i_mask_set(mask_set), .o_cpu_mask_level(cpu_mask), .o_fetch_addr(fetch));

	initial begin
		forever #2.5 i_clk = ~i_clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic wrap_up();
		if (err_total == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] sv, input logic [31:0] ev);
		checks++;
		if (sv !== ev) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, ev, sv);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		bus.wr <= 1'b0;
		if (a[1:0] == 2'b00 && a[7:5] == 3'b000) begin
			pr[a[4:2]] = d;
		end
	endtask

	task automatic rd_all();
		for (int a = 0; a < 42; a += 2) begin
			@(posedge i_clk);
			bus <= '{wr: 1'b0, rd: 1'b1, addr: 8'(a), wdata: 16'h0000};
			@(posedge i_clk);
			bus.rd <= 1'b0;
			#1;
			chk("rdata", 32'(rdata), (a % 4 == 0 && a < 32) ? 32'(pr[a / 4]) : 0);
		end
	endtask

	function automatic ivp_irq_t model(input logic [IVP_NUM_SRC-1:0] r, input logic [3:0] m);
		ivp_irq_t e;
		int best;
		int lvl;
		e = '0;
		best = 0;
		for (int i = 0; i < IVP_NUM_SRC; i++) begin
			lvl = IVP_SRC_TAB[i].fixed ? int'(IVP_SRC_TAB[i].flvl)
				: (pr[IVP_SRC_TAB[i].ri] >> (4 * IVP_SRC_TAB[i].nib)) & 15;
			// Strictly greater keeps the earlier source on a tie.
			if (r[i] && lvl > best) begin
				best = lvl;
				e.vector = IVP_SRC_TAB[i].vec;
			end
		end
		if (best > int'(m)) begin
			e = '{req: 1'b1, vector: e.vector, level: 5'(best), addr: 32'(e.vector) * 4};
		end else begin
			e = '0;
		end
		return e;
	endfunction

	task automatic chk_irq();
		ivp_irq_t e;
		repeat (3) @(posedge i_clk);
		#1;
		e = model(src, mask_set);
		chk("irq.req", 32'(irq.req), 32'(e.req));
		chk("irq.vector", 32'(irq.vector), 32'(e.vector));
		chk("irq.level", 32'(irq.level), 32'(e.level));
		chk("irq.addr", irq.addr, e.addr);
		if (e.req) begin
			chk("fetch", fetch, e.addr);
		end
		// Realign so the next stimulus is driven on a rising edge.
		@(posedge i_clk);
	endtask

	task automatic reset_check();
		i_sys_rst <= 1'b1;
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		src <= {{(IVP_NUM_SRC - 3){1'b1}}, 3'b000};
		mask_set <= 4'h0;
		foreach (pr[k]) begin
			pr[k] = 0;
		end
		chk_irq();
		rd_all();
	endtask

	initial begin
		reset_check();
		for (int a = 0; a < 40; a += 2) begin
			rnd = lfsr(rnd);
			wr_reg(8'(a), rnd);
		end
		rd_all();
		// A read right behind its write must already see the new value.
		@(posedge i_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: IVP_OFS_LATE, wdata: 16'h0A5C};
		@(posedge i_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: IVP_OFS_LATE, wdata: 16'h0000};
		pr[IVP_RI_LATE] = 16'h0A5C;
		@(posedge i_clk);
		bus.rd <= 1'b0;
		#1;
		chk("rdback", 32'(rdata), 32'(pr[IVP_RI_LATE]));
		for (int a = 0; a < 32; a += 4) begin
			wr_reg(8'(a), 16'hFFFF);
		end
		for (int i = 0; i < IVP_NUM_SRC; i++) begin
			src <= 56'(1) << i;
			chk_irq();
			got[i] = 32'(irq.vector);
			chk("vec.unique", 32'(vec_used.exists(int'(irq.vector))), 0);
			vec_used[int'(irq.vector)] = 1;
		end
		chk("vec.nmi", got[IVP_SRC_NMI], 32'h0000_000B);
		chk("vec.brk", got[IVP_SRC_BRK], 32'h0000_000C);
		chk("vec.dbg", got[IVP_SRC_DBG], 32'h0000_000E);
		chk("vec.tmr0ovf", got[IVP_SRC_TMR0_OVF], 32'h0000_005C);
		for (int k = 0; k < 4; k++) begin
			chk("vec.tmr0", got[IVP_SRC_TMR0_CMPA + k], 32'h0000_0058 + k);
			chk("vec.ser3", got[IVP_SRC_SER3_RXERR + k], 32'h0000_00AC + k);
		end
		src <= 56'(4'hF) << IVP_SRC_IRQ0;
		for (int k = 0; k < 4; k++) begin
			wr_reg(IVP_OFS_PIN, 16'h0001 << (12 - 4 * k));
			chk_irq();
			chk("pin.vec", 32'(irq.vector), 32'h0000_0040 + k);
		end
		src <= 56'(8'hFF) << 37;
		wr_reg(IVP_OFS_SER, 16'h0F00);
		chk_irq();
		chk("ser3.vec", 32'(irq.vector), 32'h0000_00AC);
		wr_reg(IVP_OFS_PIN, 16'h5000);
		src <= 56'(1) << IVP_SRC_IRQ0;
		for (int m = 3; m < 7; m++) begin
			mask_set <= 4'(m);
			chk_irq();
		end
		// Levels limited to 0..3 so that ties and masking happen often.
		for (int n = 0; n < 400; n++) begin
			rnd = lfsr(rnd);
			wr_reg({3'h0, rnd[7:5], 2'b00}, lfsr(rnd) & 16'h3333);
			rnd = lfsr(rnd);
			src <= {rnd[4:0], rnd, lfsr(rnd), ~rnd, rnd[15:13] == 3'h0 ? rnd[2:0] : 3'h0};
			mask_set <= {2'b00, rnd[9:8]};
			chk_irq();
		end
		reset_check();
		wrap_up();
	end

	// The full sequence needs about 2900 cycles; the limit leaves wide margin.
	initial begin
		#100_000;
		err_total++;
		wrap_up();
	end
endmodule
`default_nettype wire
